//--- include/ssre_pkg.sv
package ssre_pkg;
  // register byte offsets
  localparam logic [7:0] SSRE_OFF_CTRL = 8'h00;
  localparam logic [7:0] SSRE_OFF_DELAY = 8'h04;
  localparam logic [7:0] SSRE_OFF_SCALE = 8'h08;
  localparam logic [7:0] SSRE_OFF_MISMATCH = 8'h0C;
  localparam logic [7:0] SSRE_OFF_STATUS = 8'h10;
  localparam logic [7:0] SSRE_OFF_SPEED = 8'h14;
  localparam logic [7:0] SSRE_OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] SSRE_OFF_IRQ_MASK = 8'h1C;
  // ctrl fields
  localparam int SSRE_CTRL_MODE_A_LSB = 0;
  localparam int SSRE_CTRL_MODE_B_LSB = 2;
  localparam int SSRE_CTRL_STARTUP_BIT = 4;
  localparam int SSRE_CTRL_SPEED_EN_BIT = 5;
  // delay fields
  localparam int SSRE_DLY_A_LSB = 0;
  localparam int SSRE_DLY_B_LSB = 8;
  localparam int SSRE_DLY_RESP_LSB = 16;
  // scale fields
  localparam int SSRE_SCALE_C_LSB = 0;
  localparam int SSRE_SCALE_D_LSB = 16;
  // status / irq bits
  localparam int SSRE_ST_OUT_A_BIT = 0;
  localparam int SSRE_ST_OUT_B_BIT = 1;
  localparam int SSRE_ST_READY_BIT = 2;
  localparam int SSRE_ST_ERR_BIT = 3;
  localparam int SSRE_ST_CLEAR_BIT = 4;
  localparam int SSRE_IRQ_INTRUDE_BIT = 0;
  localparam int SSRE_IRQ_MISMATCH_BIT = 1;
  localparam int SSRE_IRQ_READY_BIT = 2;
  // reset values
  localparam logic [31:0] SSRE_RST_CTRL = 32'h00000000;
  localparam logic [31:0] SSRE_RST_DELAY = 32'h00000202;
  localparam logic [31:0] SSRE_RST_SCALE = 32'h00320032;
  localparam logic [31:0] SSRE_RST_MISMATCH = 32'h00000019;
  localparam logic [31:0] SSRE_RST_IRQ_MASK = 32'h00000000;
  // timing
  localparam int SSRE_CLK_MHZ = 100;
  localparam int SSRE_MS_US = 1000;
  localparam int SSRE_MS_CYCLES = SSRE_MS_US * SSRE_CLK_MHZ;
  localparam int SSRE_MS_PER_S = 1000;
  localparam int SSRE_WIN_MS = 100;
  localparam int SSRE_WIN_PER_S = SSRE_MS_PER_S / SSRE_WIN_MS;
  localparam int SSRE_MIN_SPEED_CMS = 10;
  localparam int SSRE_PCT_FULL = 100;
  localparam int SSRE_SYNC_W = 4;

  typedef enum logic [1:0] {
    SSRE_MODE_INHIBIT,
    SSRE_MODE_NODELAY,
    SSRE_MODE_DELAYED,
    SSRE_MODE_RSVD
  } ssre_mode_t;

  typedef enum logic [1:0] {
    SSRE_OUT_OFF,
    SSRE_OUT_WAIT,
    SSRE_OUT_ON
  } ssre_out_state_t;

  typedef enum logic [1:0] {
    SSRE_BUS_IDLE,
    SSRE_BUS_WAIT,
    SSRE_BUS_DONE
  } ssre_bus_state_t;

  typedef struct packed {
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] haddr;
  } ssre_ahb_req_t;

  typedef struct packed {
    logic [15:0] speed_d;
    logic [15:0] speed_c;
  } ssre_speed_t;
endpackage

//--- src/ssre_speed_chan.sv
`timescale 1ns/100ps
module ssre_speed_chan #(
  parameter int CNT_W = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enc_level,
  input wire logic win_end,
  input wire logic [15:0] ppcm,
  output logic [15:0] speed,
  output logic speed_valid
);
  import ssre_pkg::*;

  localparam int DIV_W = CNT_W + 4;

  initial begin
    if (CNT_W < 8 || CNT_W > 27) begin
      $error("ssre_speed_chan: CNT_W out of range");
    end
  end

  logic prev_reg, prev_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DIV_W-1:0] num_reg, num_next;
  logic [DIV_W-1:0] quo_reg, quo_next;
  logic [16:0] rem_reg, rem_next;
  logic [4:0] bit_reg, bit_next;
  logic busy_reg, busy_next;
  logic [15:0] speed_reg, speed_next;
  logic valid_reg, valid_next;

  always_comb begin
    logic [16:0] trial;
    trial = '0;
    prev_next = enc_level;
    cnt_next = cnt_reg;
    num_next = num_reg;
    quo_next = quo_reg;
    rem_next = rem_reg;
    bit_next = bit_reg;
    busy_next = busy_reg;
    speed_next = speed_reg;
    valid_next = 1'b0;
    if (enc_level && !prev_reg && cnt_reg != '1) begin
      cnt_next = cnt_reg + 1'b1;
    end
    if (win_end) begin
      // pulses per window scaled to pulses per second
      num_next = DIV_W'(cnt_next) * DIV_W'(SSRE_WIN_PER_S);
      cnt_next = '0;
      quo_next = '0;
      rem_next = '0;
      bit_next = 5'(DIV_W - 1);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      trial = {rem_reg[15:0], num_reg[bit_reg]};
      if (trial >= {1'b0, ppcm}) begin
        rem_next = trial - {1'b0, ppcm};
        quo_next = quo_reg | (DIV_W'(1) << bit_reg);
      end else begin
        rem_next = trial;
      end
      if (bit_reg == 5'h00) begin
        busy_next = 1'b0;
        valid_next = 1'b1;
        if (ppcm == 16'h0000 || quo_next < DIV_W'(SSRE_MIN_SPEED_CMS)) begin
          speed_next = 16'h0000;
        end else if (quo_next > DIV_W'(16'hFFFF)) begin
          speed_next = 16'hFFFF;
        end else begin
          speed_next = quo_next[15:0];
        end
      end else begin
        bit_next = bit_reg - 5'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= 1'b0;
      cnt_reg <= '0;
      num_reg <= '0;
      quo_reg <= '0;
      rem_reg <= '0;
      bit_reg <= 5'h00;
      busy_reg <= 1'b0;
      speed_reg <= 16'h0000;
      valid_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
      num_reg <= num_next;
      quo_reg <= quo_next;
      rem_reg <= rem_next;
      bit_reg <= bit_next;
      busy_reg <= busy_next;
      speed_reg <= speed_next;
      valid_reg <= valid_next;
    end
  end

  assign speed = speed_reg;
  assign speed_valid = valid_reg;
endmodule

//--- src/ssre_top.sv
`timescale 1ns/100ps
// Contract
// - in no-delay mode an output turns on once the field is clear and the response time ran out.
// - in delayed mode an output turns on only after the set seconds of clear field.
// - ready sets one cycle after reset, while startup testing is still off, and never clears, so turning it on holds nothing back.
// - each encoder's pulses are scaled to travel by its own pulses-per-cm factor.
// - a mismatch limit in percent is held and both speeds are compared against it.
// - speeds below 10 cm/s are reported as zero.
// - in restart-inhibit mode an output turns on only with clear field and a restart request.
// - outputs A and B each have their own restart mode.
// - with speed evaluation on, inputs C and D serve the encoders only.
module ssre_top #(
  parameter int MS_CYCLES = ssre_pkg::SSRE_MS_CYCLES,
  parameter int WIN_MS = ssre_pkg::SSRE_WIN_MS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire ssre_pkg::ssre_ahb_req_t ahb_req,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic field_clear,
  input wire logic restart_req,
  input wire logic gen_in_c,
  input wire logic gen_in_d,
  output logic gen_c,
  output logic gen_d,
  output logic safety_switching_output_a,
  output logic safety_switching_output_b,
  output logic irq
);
  import ssre_pkg::*;

  localparam int CHAN_CNT_W = 20;

  initial begin
    if (MS_CYCLES < 2 || MS_CYCLES > 1048575 || WIN_MS < 1 || WIN_MS > 65535) begin
      $error("ssre_top: timing parameter out of range");
    end
    // a window shorter than one divide restarts it forever
    if (longint'(MS_CYCLES) * longint'(WIN_MS) <= longint'(CHAN_CNT_W + 5)) begin
      $error("ssre_top: speed window shorter than the divide");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: field clear, restart, input c, input d
  logic [SSRE_SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  always_comb begin
    filt_next = filt_reg;
    for (int i = 0; i < SSRE_SYNC_W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= {gen_in_d, gen_in_c, restart_req, field_clear};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end
  logic clear_f, restart_f;
  assign clear_f = filt_reg[0];
  assign restart_f = filt_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick and speed window
  logic [19:0] ms_reg, ms_next;
  logic [15:0] win_reg, win_next;
  logic ms_tick, win_end;
  assign ms_tick = (ms_reg == 20'(MS_CYCLES - 1));
  assign win_end = ms_tick && (win_reg == 16'(WIN_MS - 1));
  always_comb begin
    ms_next = ms_tick ? 20'h00000 : ms_reg + 20'h00001;
    win_next = win_reg;
    if (ms_tick) begin
      win_next = win_end ? 16'h0000 : win_reg + 16'h0001;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_reg <= 20'h00000;
      win_reg <= 16'h0000;
    end else begin
      ms_reg <= ms_next;
      win_reg <= win_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and ahb-lite slave
  ssre_bus_state_t bs_reg, bs_next;
  logic [7:0] addr_reg, addr_next;
  logic wr_reg, wr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] ctrl_reg, ctrl_next, delay_reg, delay_next, scale_reg, scale_next;
  logic [31:0] mism_reg, mism_next, istat_reg, istat_next, imask_reg, imask_next;
  logic [2:0] ev;
  logic [31:0] status_w;
  ssre_speed_t speed_w;
  logic speed_en;
  assign speed_en = ctrl_reg[SSRE_CTRL_SPEED_EN_BIT];

  always_comb begin
    bs_next = bs_reg;
    addr_next = addr_reg;
    wr_next = wr_reg;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    delay_next = delay_reg;
    scale_next = scale_reg;
    mism_next = mism_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    if (bs_reg == SSRE_BUS_WAIT) begin
      bs_next = SSRE_BUS_DONE;
      if (wr_reg) begin
        case (addr_reg)
          SSRE_OFF_CTRL: ctrl_next = {26'h0, hwdata[5:0]};
          SSRE_OFF_DELAY: delay_next = {8'h00, hwdata[23:0]};
          SSRE_OFF_SCALE: scale_next = hwdata;
          SSRE_OFF_MISMATCH: mism_next = {24'h0, hwdata[7:0]};
          SSRE_OFF_IRQ_STAT: istat_next = istat_reg & ~{29'h0, hwdata[2:0]};
          SSRE_OFF_IRQ_MASK: imask_next = {29'h0, hwdata[2:0]};
          default: ;
        endcase
      end else begin
        case (addr_reg)
          SSRE_OFF_CTRL: rdata_next = ctrl_reg;
          SSRE_OFF_DELAY: rdata_next = delay_reg;
          SSRE_OFF_SCALE: rdata_next = scale_reg;
          SSRE_OFF_MISMATCH: rdata_next = mism_reg;
          SSRE_OFF_STATUS: rdata_next = status_w;
          SSRE_OFF_SPEED: rdata_next = speed_w;
          SSRE_OFF_IRQ_STAT: rdata_next = istat_reg;
          SSRE_OFF_IRQ_MASK: rdata_next = imask_reg;
          default: rdata_next = 32'h00000000;
        endcase
      end
    end else begin
      bs_next = SSRE_BUS_IDLE;
    end
    if (hsel && hready && ahb_req.htrans[1]) begin
      bs_next = SSRE_BUS_WAIT;
      addr_next = {ahb_req.haddr[7:2], 2'b00};
      wr_next = ahb_req.hwrite;
    end
    // new events win over a write-one clear
    istat_next = istat_next | {29'h0, ev};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bs_reg <= SSRE_BUS_IDLE;
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ctrl_reg <= SSRE_RST_CTRL;
      delay_reg <= SSRE_RST_DELAY;
      scale_reg <= SSRE_RST_SCALE;
      mism_reg <= SSRE_RST_MISMATCH;
      istat_reg <= 32'h00000000;
      imask_reg <= SSRE_RST_IRQ_MASK;
    end else begin
      bs_reg <= bs_next;
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      delay_reg <= delay_next;
      scale_reg <= scale_next;
      mism_reg <= mism_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
    end
  end
  assign hreadyout = (bs_reg != SSRE_BUS_WAIT);
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign irq = |(istat_reg & imask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // speed channels and mismatch check
  logic vld_c, vld_d;
  logic err_reg, err_next;
  ssre_speed_chan #(.CNT_W(CHAN_CNT_W)) u_chan_c (
    .hclk(hclk),
    .hresetn(hresetn),
    .enc_level(filt_reg[2] & speed_en),
    .win_end(win_end),
    .ppcm(scale_reg[SSRE_SCALE_C_LSB +: 16]),
    .speed(speed_w.speed_c),
    .speed_valid(vld_c)
  );
  ssre_speed_chan #(.CNT_W(CHAN_CNT_W)) u_chan_d (
    .hclk(hclk),
    .hresetn(hresetn),
    .enc_level(filt_reg[3] & speed_en),
    .win_end(win_end),
    .ppcm(scale_reg[SSRE_SCALE_D_LSB +: 16]),
    .speed(speed_w.speed_d),
    .speed_valid(vld_d)
  );
  assign gen_c = speed_en ? 1'b0 : filt_reg[2];
  assign gen_d = speed_en ? 1'b0 : filt_reg[3];

  always_comb begin
    logic [31:0] diff, hi;
    diff = (speed_w.speed_c > speed_w.speed_d) ?
      32'(speed_w.speed_c - speed_w.speed_d) : 32'(speed_w.speed_d - speed_w.speed_c);
    hi = (speed_w.speed_c > speed_w.speed_d) ? 32'(speed_w.speed_c) : 32'(speed_w.speed_d);
    err_next = err_reg;
    if (!speed_en) begin
      err_next = 1'b0;
    end else if (vld_c && vld_d) begin
      err_next = (diff * 32'(SSRE_PCT_FULL)) > (hi * 32'(mism_reg[7:0]));
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // startup test and per-output restart
  ssre_out_state_t st_reg [2], st_next [2];
  logic [19:0] tmr_reg [2], tmr_next [2];
  logic [1:0] out_reg, out_next;
  logic ready_reg, ready_next, clr_d_reg, rst_d_reg;
  logic intrude, restart_rise;
  assign intrude = clr_d_reg && !clear_f;
  assign restart_rise = restart_f && !rst_d_reg;
  assign ev = {ready_next && !ready_reg, err_next && !err_reg, intrude};

  always_comb begin
    ssre_mode_t md;
    md = SSRE_MODE_INHIBIT;
    ready_next = ready_reg;
    if (!ctrl_reg[SSRE_CTRL_STARTUP_BIT] || !clear_f) begin
      ready_next = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      md = ssre_mode_t'(ctrl_reg[(i * 2) +: 2]);
      st_next[i] = st_reg[i];
      tmr_next[i] = tmr_reg[i];
      case (st_reg[i])
        SSRE_OUT_OFF: begin
          if (clear_f && ready_reg && !err_reg) begin
            case (md)
              SSRE_MODE_NODELAY: begin
                st_next[i] = SSRE_OUT_WAIT;
                tmr_next[i] = 20'(delay_reg[SSRE_DLY_RESP_LSB +: 8]);
              end
              SSRE_MODE_DELAYED: begin
                st_next[i] = SSRE_OUT_WAIT;
                tmr_next[i] = 20'(delay_reg[(i * 8) +: 8]) * 20'(SSRE_MS_PER_S);
              end
              default: begin
                if (restart_rise) begin
                  st_next[i] = SSRE_OUT_ON;
                end
              end
            endcase
          end
        end
        SSRE_OUT_WAIT: begin
          if (tmr_reg[i] == 20'h00000) begin
            st_next[i] = SSRE_OUT_ON;
          end else if (ms_tick) begin
            tmr_next[i] = tmr_reg[i] - 20'h00001;
          end
        end
        default: ;
      endcase
      if (!clear_f || err_reg || !ready_reg) begin
        st_next[i] = SSRE_OUT_OFF;
      end
      out_next[i] = (st_next[i] == SSRE_OUT_ON);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        st_reg[i] <= SSRE_OUT_OFF;
        tmr_reg[i] <= 20'h00000;
      end
      out_reg <= 2'b00;
      ready_reg <= 1'b0;
      clr_d_reg <= 1'b0;
      rst_d_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      out_reg <= out_next;
      ready_reg <= ready_next;
      clr_d_reg <= clear_f;
      rst_d_reg <= restart_f;
    end
  end
  assign safety_switching_output_a = out_reg[0];
  assign safety_switching_output_b = out_reg[1];
  assign status_w = {27'h0, clear_f, err_reg, ready_reg, out_reg};
endmodule

//--- tb/ssre_props.sv
`timescale 1ns/100ps
module ssre_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire ssre_pkg::ssre_ahb_req_t ahb_req,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic field_clear,
  input wire logic gen_in_c,
  input wire logic gen_c,
  input wire logic safety_switching_output_a,
  input wire logic safety_switching_output_b,
  input wire logic irq
);
  import ssre_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_addr;
    hsel && hready && ahb_req.htrans[1];
  endsequence
  sequence s_blocked;
    !field_clear [*8];
  endsequence
  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("bus response not okay");
  property p_wait; s_addr |=> !hreadyout ##1 hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("transfer not one wait state");
  property p_rdata; !$stable(hrdata) |-> !$past(hreadyout); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved outside a transfer");
  property p_off_a; s_blocked |-> !safety_switching_output_a; endproperty
  a_off_a: assert property (p_off_a) else $error("output a on with field blocked");
  property p_off_b; s_blocked |-> !safety_switching_output_b; endproperty
  a_off_b: assert property (p_off_b) else $error("output b on with field blocked");
  property p_rise_a; $rose(safety_switching_output_a) |-> $past(field_clear, 3); endproperty
  a_rise_a: assert property (p_rise_a) else $error("output a rose too early");
  property p_rise_b; $rose(safety_switching_output_b) |-> $past(field_clear, 3); endproperty
  a_rise_b: assert property (p_rise_b) else $error("output b rose too early");
  property p_gen; $rose(gen_c) |-> $past(gen_in_c, 3); endproperty
  a_gen: assert property (p_gen) else $error("general input c rose without pin");
  property p_irq; $fell(irq) |-> !$past(hreadyout); endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped without a write");
endmodule
bind ssre_top ssre_props ssre_props_inst (
  .hclk, .hresetn, .hsel, .ahb_req, .hready, .hrdata, .hreadyout, .hresp,
  .field_clear, .gen_in_c, .gen_c, .safety_switching_output_a,
  .safety_switching_output_b, .irq
);

//--- tb/ssre_partner.sv
`timescale 1ns/100ps
module ssre_partner (
  input wire logic hclk,
  input wire logic enc_run,
  input wire logic field_cmd,
  input wire logic restart_cmd,
  output logic field_clear,
  output logic restart_req,
  output logic enc_c,
  output logic enc_d
);
  logic [2:0] ph;
  initial ph = 3'h0;
  always @(posedge hclk) ph <= ph + 3'h1;
  // one wheel seen by both encoders, idle level high
  assign enc_c = enc_run ? ph[2] : 1'b1;
  assign enc_d = enc_c;
  // field intrusion and release as commanded
  assign field_clear = field_cmd;
  // restart button, pressed early only when a test asks for it
  assign restart_req = restart_cmd;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ssre_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } ssre_row_t;
  logic hclk, hresetn, hsel, hready, hresp, hreadyout, irq;
  ssre_ahb_req_t ahb_req;
  logic [31:0] hwdata, hrdata, rd, pins;
  logic field_cmd, restart_cmd, enc_run, field_clear, restart_req, enc_c, enc_d;
  logic gen_c, gen_d, out_a, out_b;
  int errors, n_checks, cyc;
  ssre_row_t rows [12];
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  assign hready = hreadyout;
  assign pins = {27'h0, irq, gen_c, gen_d, out_b, out_a};
  ssre_top #(.MS_CYCLES(10), .WIN_MS(4)) ssre_top_inst (
    .hclk, .hresetn, .hsel, .ahb_req, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .field_clear, .restart_req, .gen_in_c(enc_c), .gen_in_d(enc_d), .gen_c, .gen_d,
    .safety_switching_output_a(out_a), .safety_switching_output_b(out_b), .irq
  );
  ssre_partner ssre_partner_inst (
    .hclk, .enc_run, .field_cmd, .restart_cmd, .field_clear, .restart_req, .enc_c, .enc_d
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    ahb_req <= '{2'b10, wr, 3'b010, {24'h0, a}};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    ahb_req <= '{2'b00, 1'b0, 3'b010, 32'h0};
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  task automatic press;
    restart_cmd <= 1'b1;
    repeat (10) @(posedge hclk);
    restart_cmd <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    ahb_req = '0;
    hwdata = 32'h0;
    field_cmd = 1'b0;
    restart_cmd = 1'b0;
    enc_run = 1'b0;
    rows = '{
      '{1'b0, SSRE_OFF_CTRL, 32'h0, SSRE_RST_CTRL},
      '{1'b0, SSRE_OFF_DELAY, 32'h0, SSRE_RST_DELAY},
      '{1'b0, SSRE_OFF_SCALE, 32'h0, SSRE_RST_SCALE},
      '{1'b0, SSRE_OFF_MISMATCH, 32'h0, SSRE_RST_MISMATCH},
      '{1'b0, SSRE_OFF_IRQ_MASK, 32'h0, SSRE_RST_IRQ_MASK},
      '{1'b1, 8'h24, 32'hFFFFFFFF, 32'h0},
      '{1'b1, SSRE_OFF_MISMATCH, 32'h00000032, 32'h00000032},
      '{1'b1, SSRE_OFF_MISMATCH, 32'h00000019, 32'h00000019},
      '{1'b1, SSRE_OFF_IRQ_MASK, 32'h00000007, 32'h00000007},
      '{1'b1, SSRE_OFF_DELAY, 32'h00020001, 32'h00020001},
      '{1'b1, SSRE_OFF_SCALE, 32'h00010001, 32'h00010001},
      '{1'b1, SSRE_OFF_IRQ_STAT, 32'h00000007, 32'h0}
    };
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk("register", rd, rows[i].e);
    end
    chk("pins idle", pins, 32'h0C);
    // a delayed 1 s, b without delay, startup test on
    bus(1'b1, SSRE_OFF_CTRL, 32'h16);
    field_cmd <= 1'b1;
    repeat (12) @(posedge hclk);
    chk("pins before response", pins, 32'h0C);
    repeat (88) @(posedge hclk);
    chk("pins b on", pins, 32'h0E);
    repeat (9800) @(posedge hclk);
    chk("pins a held", pins, 32'h0E);
    repeat (400) @(posedge hclk);
    chk("pins a on", pins, 32'h0F);
    rd_chk("status", SSRE_OFF_STATUS, 32'h1F, 32'h17);
    field_cmd <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("pins intruded", pins, 32'h1C);
    rd_chk("intrude flag", SSRE_OFF_IRQ_STAT, 32'h1, 32'h1);
    bus(1'b1, SSRE_OFF_IRQ_STAT, 32'h1);
    chk("pins cleared", pins, 32'h0C);
    bus(1'b1, SSRE_OFF_IRQ_MASK, 32'h2);
    // a inhibit, b reserved code; early press must be ignored
    bus(1'b1, SSRE_OFF_CTRL, 32'h0C);
    press();
    field_cmd <= 1'b1;
    repeat (100) @(posedge hclk);
    chk("pins no request", pins, 32'h0C);
    press();
    repeat (10) @(posedge hclk);
    chk("pins restarted", pins, 32'h0F);
    bus(1'b1, SSRE_OFF_CTRL, 32'h2C);
    enc_run <= 1'b1;
    repeat (160) @(posedge hclk);
    chk("pins speed on", pins, 32'h03);
    bus(1'b0, SSRE_OFF_SPEED, 32'h0);
    chk("speed equal", rd, 32'h00320032);
    rd_chk("no error", SSRE_OFF_STATUS, 32'h8, 32'h0);
    bus(1'b1, SSRE_OFF_SCALE, 32'h0001000A);
    repeat (100) @(posedge hclk);
    bus(1'b0, SSRE_OFF_SPEED, 32'h0);
    chk("speed dead band", rd, 32'h00320000);
    chk("pins mismatch", pins, 32'h10);
    rd_chk("error bit", SSRE_OFF_STATUS, 32'h8, 32'h8);
    rd_chk("mismatch flag", SSRE_OFF_IRQ_STAT, 32'h2, 32'h2);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("pins in reset", pins, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("ctrl after reset", SSRE_OFF_CTRL, 32'hFFFFFFFF, SSRE_RST_CTRL);
    end_of_test();
  end
endmodule
